// *** bench/tb_time_sliced_tributary_hdlc_link.sv ***
`timescale 1ns/100ps
module tb_time_sliced_tributary_hdlc_link
  import trib_link_pkg::*;
;
  typedef struct packed {logic wr_op; logic [9:0] a; logic [7:0] d; logic [7:0] m;} row_t;
  logic core_clk;
  logic rst_b;
  logic [9:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic irq_out_n;
  logic line_rx_bit;
  logic line_rx_valid;
  logic [TRIB_W-1:0] cap_trib;
  logic cap_sel;
  logic [15:0] cap_sh;
  logic [7:0] d;
  logic [7:0] st;
  int run;
  int run_max;
  int fails;
  int check_count;
  int n;
  row_t rows [11] = '{'{1'b0, 10'h11d, 8'h08, 8'hff}, '{1'b1, 10'h11d, 8'h05, 8'h00},
    '{1'b0, 10'h11d, 8'h05, 8'hff}, '{1'b0, 10'h136, 8'h40, 8'hff}, '{1'b0, 10'h137, 8'h10, 8'hff},
    '{1'b1, 10'h3ff, 8'hff, 8'h00}, '{1'b0, 10'h3ff, 8'h00, 8'hff}, '{1'b1, 10'h118, 8'h85, 8'h00},
    '{1'b0, 10'h11c, 8'h00, 8'h03}, '{1'b1, 10'h131, 8'h80, 8'h00}, '{1'b0, 10'h139, 8'h40, 8'h70}};
  trib_link_if lnk();
  trib_link_device u_trib_link_device(.core_clk(core_clk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .irq_out_n(irq_out_n), .link(lnk));
  trib_link_framer u_trib_link_framer(.core_clk(core_clk), .rst_b(rst_b), .line_rx_bit(line_rx_bit),
    .line_rx_valid(line_rx_valid), .line_tx_bit(), .line_tx_valid(), .link(lnk));
  trib_link_sva u_trib_link_sva(.core_clk(core_clk), .rst_b(rst_b), .rx_trib(lnk.rx_trib),
    .rx_bit(lnk.rx_bit), .rx_bit_valid(lnk.rx_bit_valid), .tx_trib(lnk.tx_trib),
    .tx_bit_req(lnk.tx_bit_req), .tx_bit(lnk.tx_bit));
  always #25 core_clk = ~core_clk;
  // bit stream of one watched tributary
  always @(posedge core_clk) begin
    cap_sel <= lnk.tx_bit_req && lnk.tx_trib == cap_trib;
    if (cap_sel) begin
      cap_sh <= {lnk.tx_bit, cap_sh[15:1]};
      run <= lnk.tx_bit ? run + 1 : 0;
      if (lnk.tx_bit && run + 1 > run_max) run_max <= run + 1;
    end
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tmo(input logic ok);
    if (ok !== 1'b1) begin
      fails++;
      $display("unexpected at %0t: wait ran out %h %h", $time, ok, 1'b1);
      test_done();
    end
  endtask
  task automatic wreg(input logic [9:0] a, input logic [7:0] v);
    @(posedge core_clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [9:0] a, output logic [7:0] v);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    @(negedge core_clk);
    v = rdata;
  endtask
  task automatic poll(input logic [9:0] a, output logic [7:0] s);
    int k;
    s = 8'hff;
    for (k = 0; k < 64 && s[BUSY_BIT] !== 1'b0; k++) rreg(a, s);
    tmo(s[BUSY_BIT] === 1'b0);
  endtask
  task automatic rx_fetch(input logic [7:0] t, output logic [7:0] b);
    wreg(RX_ADDR_OFS, 8'h80 | t);
    wreg(RX_ISTAT_OFS, START_READ);
    poll(RX_STAT_OFS, st);
    rreg(RX_BYTE_OFS, b);
  endtask
  task automatic tx_send(input logic [7:0] t, input logic [7:0] cfg, input logic [23:0] v, input int cnt,
    input logic end_of_message);
    int i;
    wreg(TX_ADDR_OFS, 8'h80 | t);
    wreg(TX_CFG_OFS, cfg);
    wreg(TX_STAT_OFS, 8'h00);
    wreg(TX_CTRL_OFS, 8'h00);
    for (i = 0; i < cnt; i++) begin
      poll(TX_STAT_OFS, st);
      if (end_of_message && i == cnt - 1) wreg(TX_CTRL_OFS, 8'h01);
      wreg(TX_BYTE_OFS, v[8*i +: 8]);
    end
  endtask
  initial begin
    core_clk = 1'b0;
    rst_b = 1'b0;
    {addr, wdata, wr, rd, line_rx_valid, cap_sel, cap_sh} = '0;
    line_rx_bit = 1'b1;
    cap_trib = 7'h03;
    {run, run_max, fails, check_count} = '0;
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (2) @(negedge core_clk);
    chk({6'h00, irq_out_n, u_trib_link_framer.line_tx_valid}, 8'h02);
    $display("test reset done");
    foreach (rows[i]) begin
      if (rows[i].wr_op) wreg(rows[i].a, rows[i].d);
      else begin
        rreg(rows[i].a, d);
        chk(d & rows[i].m, rows[i].d);
      end
    end
    $display("test table done");
    wreg(RX_ADDR_OFS, 8'h85);
    wreg(RX_CFG_OFS, 8'h03);
    wreg(RX_ADDR_OFS, 8'h86);
    wreg(RX_CFG_OFS, 8'h02);
    line_rx_valid <= 1'b1;
    for (n = 0; n < 40000 && irq_out_n !== 1'b0; n++) @(negedge core_clk);
    tmo(irq_out_n === 1'b0);
    @(posedge core_clk);
    line_rx_valid <= 1'b0;
    rreg(RX_SUM_OFS, d);
    chk(d & 8'h60, 8'h40);
    wreg(RX_SUM_OFS, d);
    rreg(RX_SUM_OFS, d);
    chk(d & 8'h40, 8'h40);
    rx_fetch(8'h06, d);
    chk(st & 8'h47, 8'h00);
    chk(d, 8'hff);
    rx_fetch(8'h05, d);
    chk(st & 8'h40, 8'h40);
    $display("test receive done");
    tx_send(8'h03, 8'h00, 24'h003ca5, 2, 1'b1);
    for (n = 0; n < 20000 && cap_sh !== 16'h3ca5; n++) @(negedge core_clk);
    tmo(cap_sh === 16'h3ca5);
    chk(cap_sh[7:0], 8'ha5);
    chk(cap_sh[15:8], 8'h3c);
    rreg(TX_FLAGS_OFS, d);
    chk(d & 8'h30, 8'h00);
    @(negedge core_clk);
    cap_trib = 7'h04;
    run_max = 0;
    tx_send(8'h04, 8'h01, 24'h00ffff, 2, 1'b1);
    for (n = 0; n < 20000 && cap_sh[15:4] !== 12'h7df; n++) @(negedge core_clk);
    tmo(cap_sh[15:4] === 12'h7df);
    chk(cap_sh[15:8], 8'h7d);
    chk(8'(run_max), 8'h06);
    $display("test transmit done");
    @(negedge core_clk);
    cap_trib = 7'h02;
    run_max = 0;
    wreg(TX_UTHR_OFS, 8'h02);
    tx_send(8'h02, 8'h01, 24'h332211, 3, 1'b0);
    d = 8'h00;
    for (n = 0; n < 200 && d[4] !== 1'b1; n++) begin
      repeat (50) @(posedge core_clk);
      rreg(TX_FLAGS_OFS, d);
    end
    tmo(d[4] === 1'b1);
    chk(d & 8'h18, 8'h18);
    rreg(TX_FLAGS_OFS, d);
    chk(d & 8'h10, 8'h00);
    for (n = 0; n < 5000 && run_max < 7; n++) @(negedge core_clk);
    tmo(run_max >= 7);
    chk(8'(run_max >= 7), 8'h01);
    rreg(TX_SUM_OFS + 10'h002, d);
    chk(d, 8'h1c);
    wreg(TX_SUM_OFS + 10'h002, d);
    rreg(TX_SUM_OFS + 10'h002, d);
    chk(d, 8'h00);
    $display("test underrun done");
    test_done();
  end
endmodule // tb_time_sliced_tributary_hdlc_link

// *** bench/trib_link_sva.sv ***
`timescale 1ns/100ps
module trib_link_sva
  import trib_link_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [TRIB_W-1:0] rx_trib,
  input wire logic rx_bit,
  input wire logic rx_bit_valid,
  input wire logic [TRIB_W-1:0] tx_trib,
  input wire logic tx_bit_req,
  input wire logic tx_bit
);
  logic sel_ff;
  logic [7:0] ones_ff;
  logic [7:0] zeros_ff;
  logic [7:0] gap_ff;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // bit slot of idle tributary zero
  always_ff @(posedge core_clk) begin
    sel_ff <= rst_b & tx_bit_req & (tx_trib == '0);
  end
  // runs of ones and zeros
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      ones_ff <= 8'h00;
      zeros_ff <= 8'h00;
    end else if (sel_ff) begin
      ones_ff <= tx_bit ? ones_ff + 8'h01 : 8'h00;
      zeros_ff <= tx_bit ? 8'h00 : zeros_ff + 8'h01;
    end
  end
  // bits since last run of six ones
  always_ff @(posedge core_clk) begin
    if (!rst_b || ones_ff == 8'h06) gap_ff <= 8'h00;
    else if (sel_ff && gap_ff != 8'hff) gap_ff <= gap_ff + 8'h01;
  end
  property p_idle_rst; !$past(rst_b) |-> tx_bit; endproperty
  a_idle_rst: assert property (p_idle_rst)
    else $error("tx bit low after reset");
  property p_quiet_rst; !$past(rst_b) |-> !tx_bit_req && !rx_bit_valid; endproperty
  a_quiet_rst: assert property (p_quiet_rst)
    else $error("slot activity right after reset");
  property p_rx_range; rx_bit_valid |-> rx_trib < TRIB_W'(NUM_TRIB); endproperty
  a_rx_range: assert property (p_rx_range)
    else $error("rx slot out of range");
  property p_tx_range; tx_bit_req |-> tx_trib < TRIB_W'(NUM_TRIB); endproperty
  a_tx_range: assert property (p_tx_range)
    else $error("tx slot out of range");
  property p_served; tx_bit_req && tx_trib == '0 |-> ##[1:1000] (tx_bit_req && tx_trib == '0); endproperty
  a_served: assert property (p_served)
    else $error("tributary zero not served again");
  property p_ones; sel_ff |-> ones_ff <= 8'h06; endproperty
  a_ones: assert property (p_ones)
    else $error("idle stream has seven ones");
  property p_zeros; sel_ff |-> zeros_ff <= 8'h02; endproperty
  a_zeros: assert property (p_zeros)
    else $error("idle stream has three zeros");
  property p_gap; gap_ff <= 8'h10; endproperty
  a_gap: assert property (p_gap)
    else $error("no flag within sixteen bits");
  c_flag: cover property (sel_ff && ones_ff == 8'h06);
  c_rx: cover property (rx_bit_valid && rx_bit);
  c_tx3: cover property (tx_bit_req && tx_trib == 7'h03);
endmodule // trib_link_sva

// *** rtl/trib_link_device.sv ***
`timescale 1ns/100ps
// Functional notes
// RULE1 - 128-byte receive buffer per tributary
// RULE2 - receiver off at reset; per-tributary config
// RULE3 - one global receive fill setpoint
// RULE4 - hunt flag after enable or abort
// RULE5 - delineation off stores raw bytes
// RULE6 - packet end sets flag, cleared by read
// RULE7 - last byte status carries error bits
// RULE8 - fill exceeded interrupts until buffer emptied; code re-asserts it only while level above setpoint
// RULE9 - summary bits, write-one-to-clear
// RULE10 - software starts indirect read with 0x40
// RULE11 - poll busy, then read byte
// RULE12 - overrun resets pointers, drops contents
// RULE13 - status codes abort, last, data
// RULE14 - 128-byte transmit buffer, start conditions
// RULE15 - automatic report once per second
// RULE16 - hdlc mode stuffs, adds crc, flags
// RULE17 - default verbatim, flags when empty
// RULE18 - underrun aborts; flags underrun, overflow
// RULE19 - upper threshold for incomplete packets
// RULE20 - software packets at least two bytes
// RULE21 - low fill flag below lower threshold
// RULE22 - indirect write sequence with end flag
// RULE23 - shared engine, per-tributary context storage
module trib_link_device
  import trib_link_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [9:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  output logic irq_out_n,
  trib_link_if.device link
);
  // RULE23 context storage arrays
  logic [7:0] rx_mem [NUM_TRIB*DEPTH];
  logic [2:0] rx_bsm [NUM_TRIB*DEPTH];
  logic [7:0] tx_mem [NUM_TRIB*DEPTH];
  logic tx_eomm [NUM_TRIB*DEPTH];
  logic [PTR_W-1:0] rx_wp [NUM_TRIB];
  logic [PTR_W-1:0] rx_rp [NUM_TRIB];
  logic [LVL_W-1:0] rx_lvl [NUM_TRIB];
  logic [PTR_W-1:0] tx_wp [NUM_TRIB];
  logic [PTR_W-1:0] tx_rp [NUM_TRIB];
  logic [LVL_W-1:0] tx_lvl [NUM_TRIB];
  logic [7:0] rx_sh [NUM_TRIB];
  logic [2:0] rx_bc [NUM_TRIB];
  logic [2:0] rx_ones [NUM_TRIB];
  logic [15:0] rx_crc [NUM_TRIB];
  logic [NUM_TRIB-1:0] rx_hunt, rx_inpkt, rx_ovr, rx_packet_received_flag;
  logic [NUM_TRIB-1:0] rx_en, rx_delineation_enable, tx_delineation_enable, tx_go, tx_active, tx_flag_done;
  logic [NUM_TRIB-1:0] tx_udr, tx_ovf, tx_lfill, tx_prm_pend;
  logic [NUM_TRIB-1:0] rx_irq_ff, tx_irq_ff;
  logic [7:0] tx_sh [NUM_TRIB];
  logic [3:0] tx_bc [NUM_TRIB];
  logic [2:0] tx_ones [NUM_TRIB];
  logic [15:0] tx_crc [NUM_TRIB];
  logic [1:0] tx_ph [NUM_TRIB];
  logic [6:0] fill_level_setpoint_ff, upper_thr_ff, lower_threshold_level_ff;
  logic [TRIB_W-1:0] rx_sel_ff, tx_sel_ff;
  logic rx_access_ff, tx_access_ff, end_of_message_ff, tx_wmode_ff;
  logic [7:0] rx_byte_ff, rx_stat_ff;
  logic [1:0] rx_busy_ff, tx_busy_ff;
  logic [31:0] prm_cnt_ff;
  logic prm_tick;
  logic [TRIB_W-1:0] rt, tt;
  logic rbit, rvalid, treq;
  logic [7:0] nxt_rdata;
  // link inputs come from same-clock framer logic
  assign rt = link.rx_trib;
  assign rbit = link.rx_bit;
  assign rvalid = link.rx_bit_valid;
  assign tt = link.tx_trib;
  assign treq = link.tx_bit_req;

  function automatic int idx(input logic [TRIB_W-1:0] t, input logic [PTR_W-1:0] p);
    idx = int'(t) * DEPTH + int'(p);
  endfunction

  logic [7:0] rsh_n;
  logic flag_seen, abort_seen, stuffed;
  logic [NUM_TRIB-1:0] rx_sum_w1c, tx_sum_w1c, rx_lvl_hi;
  always_comb begin
    rsh_n = {rbit, rx_sh[rt][7:1]};
    // RULE8 level above setpoint
    for (int i = 0; i < NUM_TRIB; i++) rx_lvl_hi[i] = rx_lvl[i] > {1'b0, fill_level_setpoint_ff};
    flag_seen = rx_delineation_enable[rt] && rsh_n == FLAG_BYTE;
    abort_seen = rx_delineation_enable[rt] && rsh_n[7:1] == 7'h7f;
    stuffed = rx_delineation_enable[rt] && !rbit && rx_ones[rt] == 3'd5 && !rx_hunt[rt];
  end

  // receive engine
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      // RULE2 all tributaries disabled
      rx_en <= '0;
      rx_hunt <= '1;
      rx_inpkt <= '0;
      rx_ovr <= '0;
      rx_packet_received_flag <= '0;
      rx_irq_ff <= '0;
      for (int i = 0; i < NUM_TRIB; i++) begin
        rx_wp[i] <= '0;
        rx_rp[i] <= '0;
        rx_lvl[i] <= '0;
        rx_sh[i] <= '0;
        rx_bc[i] <= '0;
        rx_ones[i] <= '0;
        rx_crc[i] <= '1;
      end
      rx_busy_ff <= '0;
      rx_byte_ff <= '0;
      rx_stat_ff <= '0;
    end else begin
      // RULE8 held until write-one-to-clear; set again while level above setpoint
      rx_irq_ff <= (rx_irq_ff & ~rx_sum_w1c) | rx_lvl_hi;
      // RULE6 status read clears packet flag
      if (rd && addr == RX_STAT_OFS && rx_busy_ff == 2'd0) begin
        rx_packet_received_flag[rx_sel_ff] <= 1'b0;
        rx_ovr[rx_sel_ff] <= 1'b0;
      end
      if (rvalid && rx_en[rt] && !stuffed) begin
        rx_sh[rt] <= rsh_n;
        rx_ones[rt] <= rbit ? ((rx_ones[rt] == 3'd7) ? 3'd7 : rx_ones[rt] + 3'd1) : 3'd0;
        if (flag_seen || abort_seen) begin
          rx_bc[rt] <= '0;
          rx_crc[rt] <= '1;
          // RULE4 hunt after abort
          rx_hunt[rt] <= abort_seen;
          rx_inpkt[rt] <= 1'b0;
          if (rx_inpkt[rt] && rx_lvl[rt] < LVL_W'(DEPTH)) begin
            // RULE7 last byte status
            rx_bsm[idx(rt, rx_wp[rt] - 7'd1)] <= abort_seen ? BS_ABORT :
              {1'b1, rx_crc[rt] != CRC_GOOD, rx_bc[rt] != 3'd0};
            if (!abort_seen) begin
              // RULE6 packet end indication
              rx_packet_received_flag[rt] <= 1'b1;
              rx_irq_ff[rt] <= 1'b1;
            end
          end
        end else if (!rx_hunt[rt] || !rx_delineation_enable[rt]) begin
          rx_bc[rt] <= rx_bc[rt] + 3'd1;
          rx_crc[rt] <= crc_bit(rx_crc[rt], rbit);
          if (rx_bc[rt] == 3'd7) begin
            // RULE5 raw or delineated store
            if (rx_lvl[rt] == LVL_W'(DEPTH)) begin
              // RULE12 overrun drops contents
              rx_wp[rt] <= rx_rp[rt];
              rx_lvl[rt] <= '0;
              rx_ovr[rt] <= 1'b1;
              rx_irq_ff[rt] <= 1'b1;
            end else begin
              // RULE1 per-tributary queue
              rx_mem[idx(rt, rx_wp[rt])] <= rsh_n;
              // RULE13 ordinary data code
              rx_bsm[idx(rt, rx_wp[rt])] <= BS_DATA;
              rx_wp[rt] <= rx_wp[rt] + 7'd1;
              rx_lvl[rt] <= rx_lvl[rt] + 8'd1;
              rx_inpkt[rt] <= rx_delineation_enable[rt];
              // RULE3 RULE8 global fill setpoint
              if (rx_lvl[rt] >= {1'b0, fill_level_setpoint_ff}) begin
                rx_irq_ff[rt] <= 1'b1;
              end
            end
          end
        end
      end
      // RULE10 RULE11 indirect read
      if (rx_busy_ff != 2'd0) begin
        rx_busy_ff <= rx_busy_ff - 2'd1;
      end
      if (wr && addr == RX_ISTAT_OFS && wdata == START_READ && rx_access_ff) begin
        rx_busy_ff <= 2'(BUSY_CYCLES);
        if (rx_lvl[rx_sel_ff] != '0) begin
          rx_byte_ff <= rx_mem[idx(rx_sel_ff, rx_rp[rx_sel_ff])];
          rx_stat_ff <= {1'b0, rx_lvl[rx_sel_ff] == 8'd1, rx_ovr[rx_sel_ff], rx_packet_received_flag[rx_sel_ff], 1'b0,
                         rx_bsm[idx(rx_sel_ff, rx_rp[rx_sel_ff])]};
          rx_rp[rx_sel_ff] <= rx_rp[rx_sel_ff] + 7'd1;
          rx_lvl[rx_sel_ff] <= rx_lvl[rx_sel_ff] - 8'd1;
        end else begin
          rx_stat_ff <= {1'b0, 1'b1, rx_ovr[rx_sel_ff], rx_packet_received_flag[rx_sel_ff], 4'h0};
        end
      end
      if (wr && addr == RX_CFG_OFS) begin
        // RULE2 independent per-tributary enable
        rx_en[rx_sel_ff] <= wdata[ENABLE_BIT];
        rx_hunt[rx_sel_ff] <= 1'b1;
      end
    end
  end

  // transmit engine
  logic [7:0] tx_head;
  logic tx_head_eom, tx_empty_t, tx_start;
  always_comb begin
    tx_head = tx_mem[idx(tt, tx_rp[tt])];
    tx_head_eom = tx_eomm[idx(tt, tx_rp[tt])];
    tx_empty_t = tx_lvl[tt] == '0;
    tx_start = tx_go[tt] || tx_lvl[tt] > {1'b0, upper_thr_ff};
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      prm_cnt_ff <= '0;
      prm_tick <= 1'b0;
    end else begin
      // RULE15 one-second report timer
      prm_tick <= prm_cnt_ff == 32'(PRM_CYCLES - 1);
      prm_cnt_ff <= (prm_cnt_ff == 32'(PRM_CYCLES - 1)) ? '0 : prm_cnt_ff + 32'd1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      link.tx_bit <= 1'b1;
      tx_go <= '0;
      tx_active <= '0;
      tx_udr <= '0;
      tx_ovf <= '0;
      tx_lfill <= '0;
      tx_irq_ff <= '0;
      tx_prm_pend <= '0;
      tx_busy_ff <= '0;
      tx_flag_done <= '0;
      for (int i = 0; i < NUM_TRIB; i++) begin
        tx_wp[i] <= '0;
        tx_rp[i] <= '0;
        tx_lvl[i] <= '0;
        tx_sh[i] <= FLAG_BYTE;
        tx_bc[i] <= '0;
        tx_ones[i] <= '0;
        tx_crc[i] <= '1;
        tx_ph[i] <= '0;
      end
    end else begin
      tx_irq_ff <= tx_irq_ff & ~tx_sum_w1c;
      if (prm_tick) begin
        tx_prm_pend <= tx_delineation_enable;
      end
      if (tx_busy_ff != 2'd0) begin
        tx_busy_ff <= tx_busy_ff - 2'd1;
      end
      // RULE22 indirect write on byte register
      if (wr && addr == TX_BYTE_OFS && tx_wmode_ff && tx_access_ff) begin
        tx_busy_ff <= 2'(BUSY_CYCLES);
        if (tx_lvl[tx_sel_ff] == LVL_W'(DEPTH)) begin
          // RULE18 overflow flagged
          tx_ovf[tx_sel_ff] <= 1'b1;
          tx_irq_ff[tx_sel_ff] <= 1'b1;
        end else begin
          // RULE14 per-tributary transmit queue
          tx_mem[idx(tx_sel_ff, tx_wp[tx_sel_ff])] <= wdata;
          tx_eomm[idx(tx_sel_ff, tx_wp[tx_sel_ff])] <= end_of_message_ff;
          tx_wp[tx_sel_ff] <= tx_wp[tx_sel_ff] + 7'd1;
          tx_lvl[tx_sel_ff] <= tx_lvl[tx_sel_ff] + 8'd1;
          tx_lfill[tx_sel_ff] <= 1'b0;
          // RULE19 complete packet always sent
          if (end_of_message_ff) begin
            tx_go[tx_sel_ff] <= 1'b1;
          end
        end
      end
      if (rd && addr == TX_FLAGS_OFS) begin
        tx_ovf[tx_sel_ff] <= 1'b0;
        tx_udr[tx_sel_ff] <= 1'b0;
      end
      if (treq) begin
        // RULE16 zero-bit stuffing
        if (tx_ones[tt] == 3'd5) begin
          link.tx_bit <= 1'b0;
          tx_ones[tt] <= '0;
        end else begin
          link.tx_bit <= tx_sh[tt][0];
          tx_sh[tt] <= {1'b1, tx_sh[tt][7:1]};
          tx_ones[tt] <= (tx_ph[tt] != 2'd0 && tx_sh[tt][0]) ? tx_ones[tt] + 3'd1 : 3'd0;
          if (tx_ph[tt] == 2'd1) begin
            tx_crc[tt] <= crc_bit(tx_crc[tt], tx_sh[tt][0]);
          end
          tx_bc[tt] <= tx_bc[tt] + 4'd1;
          if (tx_bc[tt] == 4'd7) begin
            tx_bc[tt] <= '0;
            if (tx_ph[tt] == 2'd2) begin
              tx_sh[tt] <= ~tx_crc[tt][15:8];
              tx_ph[tt] <= 2'd3;
            end else if (tx_ph[tt] == 2'd3) begin
              // RULE16 closing flag
              tx_sh[tt] <= FLAG_BYTE;
              tx_ph[tt] <= 2'd0;
            end else if (tx_active[tt] && tx_empty_t) begin
              // RULE18 underrun sends abort
              tx_sh[tt] <= ABORT_BYTE;
              tx_ph[tt] <= 2'd0;
              tx_active[tt] <= 1'b0;
              tx_udr[tt] <= 1'b1;
              tx_irq_ff[tt] <= 1'b1;
            end else if (!tx_empty_t && (tx_active[tt] || tx_start || !tx_delineation_enable[tt])) begin
              // RULE17 verbatim when delineation off
              tx_sh[tt] <= tx_head;
              tx_rp[tt] <= tx_rp[tt] + 7'd1;
              tx_lvl[tt] <= tx_lvl[tt] - 8'd1;
              tx_ph[tt] <= tx_delineation_enable[tt] ? 2'd1 : 2'd0;
              if (!tx_active[tt]) begin
                tx_crc[tt] <= '1;
              end
              tx_active[tt] <= tx_delineation_enable[tt] && !tx_head_eom;
              if (tx_head_eom) begin
                tx_go[tt] <= 1'b0;
              end
              // RULE21 low fill flag
              if (tx_lvl[tt] - 8'd1 < {1'b0, lower_threshold_level_ff}) begin
                tx_lfill[tt] <= 1'b1;
                tx_irq_ff[tt] <= 1'b1;
              end
            end else if (tx_ph[tt] == 2'd1) begin
              // RULE16 crc after last byte
              tx_sh[tt] <= ~tx_crc[tt][7:0];
              tx_ph[tt] <= 2'd2;
            end else if (tx_prm_pend[tt]) begin
              // RULE15 autonomous report header
              tx_sh[tt] <= PRM_HDR0;
              tx_prm_pend[tt] <= 1'b0;
              tx_crc[tt] <= '1;
              tx_ph[tt] <= 2'd1;
            end else begin
              // RULE17 idle flags
              tx_sh[tt] <= FLAG_BYTE;
            end
          end
        end
      end
    end
  end

  // software registers
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      fill_level_setpoint_ff <= 7'h08;
      upper_thr_ff <= 7'h40;
      lower_threshold_level_ff <= 7'h10;
      rx_sel_ff <= '0;
      tx_sel_ff <= '0;
      rx_access_ff <= 1'b0;
      tx_access_ff <= 1'b0;
      end_of_message_ff <= 1'b0;
      tx_wmode_ff <= 1'b0;
      rx_delineation_enable <= '0;
      tx_delineation_enable <= '0;
    end else if (wr) begin
      unique case (addr)
        RX_ADDR_OFS: {rx_access_ff, rx_sel_ff} <= wdata;
        TX_ADDR_OFS: {tx_access_ff, tx_sel_ff} <= wdata;
        RX_INTC_OFS: fill_level_setpoint_ff <= wdata[6:0];
        TX_UTHR_OFS: upper_thr_ff <= wdata[6:0];
        TX_LINT_OFS: lower_threshold_level_ff <= wdata[6:0];
        TX_STAT_OFS: tx_wmode_ff <= wdata == 8'h00;
        TX_CTRL_OFS: end_of_message_ff <= wdata[EOM_BIT];
        RX_CFG_OFS: rx_delineation_enable[rx_sel_ff] <= wdata[DELINEATION_ENABLE_BIT];
        TX_CFG_OFS: tx_delineation_enable[tx_sel_ff] <= wdata[DELINEATION_ENABLE_BIT];
        default: ;
      endcase
    end
  end

  // RULE9 summary write-one-to-clear
  always_comb begin
    rx_sum_w1c = '0;
    tx_sum_w1c = '0;
    for (int g = 0; g < NUM_SUM; g++) begin
      for (int b = 0; b < 8; b++) begin
        if (g * 8 + b < NUM_TRIB) begin
          if (wr && addr == RX_SUM_OFS + 10'(g) && wdata[b]) rx_sum_w1c[g * 8 + b] = 1'b1;
          if (wr && addr == TX_SUM_OFS + 10'(g + 2) && wdata[b]) tx_sum_w1c[g * 8 + b] = 1'b1;
        end
      end
    end
  end

  function automatic logic [7:0] sum_byte(input logic [NUM_TRIB-1:0] v, input int g);
    sum_byte = '0;
    for (int b = 0; b < 8; b++) begin
      if (g * 8 + b < NUM_TRIB) sum_byte[b] = v[g * 8 + b];
    end
  endfunction

  always_comb begin
    nxt_rdata = '0;
    for (int g = 0; g < NUM_SUM; g++) begin
      if (addr == RX_SUM_OFS + 10'(g)) nxt_rdata = sum_byte(rx_irq_ff, g);
      if (addr == TX_SUM_OFS + 10'(g + 2)) nxt_rdata = sum_byte(tx_irq_ff, g);
    end
    // RULE8 level interrupt holds until write-one-to-clear
    if (addr == RX_SUM_OFS + 10'(NUM_SUM)) begin
      for (int g = 0; g < NUM_SUM; g++) nxt_rdata[g % 8] = nxt_rdata[g % 8] | (|sum_byte(rx_irq_ff, g));
    end
    unique case (addr)
      RX_BYTE_OFS: nxt_rdata = rx_byte_ff;
      RX_STAT_OFS: nxt_rdata = {rx_busy_ff != 2'd0, rx_stat_ff[6:0]};
      TX_STAT_OFS: nxt_rdata = {tx_busy_ff != 2'd0, 7'h0};
      TX_FLAGS_OFS: nxt_rdata = {1'b0, tx_lvl[tx_sel_ff] == '0, tx_ovf[tx_sel_ff], tx_udr[tx_sel_ff],
                                 tx_lfill[tx_sel_ff], 3'h0};
      RX_ADDR_OFS: nxt_rdata = {rx_access_ff, rx_sel_ff};
      TX_ADDR_OFS: nxt_rdata = {tx_access_ff, tx_sel_ff};
      RX_INTC_OFS: nxt_rdata = {1'b0, fill_level_setpoint_ff};
      RX_CFG_OFS: nxt_rdata = {6'h00, rx_en[rx_sel_ff], rx_delineation_enable[rx_sel_ff]};
      TX_UTHR_OFS: nxt_rdata = {1'b0, upper_thr_ff};
      TX_LINT_OFS: nxt_rdata = {1'b0, lower_threshold_level_ff};
      default: ;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rdata <= '0;
      irq_out_n <= 1'b1;
    end else begin
      rdata <= rd ? nxt_rdata : 8'h00;
      irq_out_n <= !((|rx_irq_ff) || (|tx_irq_ff));
    end
  end
endmodule // trib_link_device

// *** rtl/trib_link_framer.sv ***
`timescale 1ns/100ps
module trib_link_framer
  import trib_link_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic line_rx_bit,
  input wire logic line_rx_valid,
  output logic line_tx_bit,
  output logic line_tx_valid,
  trib_link_if.framer link
);
  logic [TRIB_W-1:0] slot_ff;
  // round-robin tributary time slices
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      slot_ff <= '0;
      link.rx_trib <= '0;
      link.rx_bit <= 1'b1;
      link.rx_bit_valid <= 1'b0;
      link.tx_trib <= '0;
      link.tx_bit_req <= 1'b0;
      line_tx_bit <= 1'b1;
      line_tx_valid <= 1'b0;
    end else begin
      slot_ff <= (slot_ff == TRIB_W'(NUM_TRIB - 1)) ? '0 : slot_ff + 7'd1;
      link.rx_trib <= slot_ff;
      link.rx_bit <= line_rx_bit;
      link.rx_bit_valid <= line_rx_valid;
      link.tx_trib <= slot_ff;
      link.tx_bit_req <= 1'b1;
      line_tx_bit <= link.tx_bit;
      line_tx_valid <= link.tx_bit_req;
    end
  end
endmodule // trib_link_framer

// *** rtl/trib_link_if.sv ***
`timescale 1ns/100ps
interface trib_link_if;
  import trib_link_pkg::*;
  logic [TRIB_W-1:0] rx_trib;
  logic rx_bit;
  logic rx_bit_valid;
  logic [TRIB_W-1:0] tx_trib;
  logic tx_bit_req;
  logic tx_bit;
  modport device (input rx_trib, input rx_bit, input rx_bit_valid, input tx_trib, input tx_bit_req, output tx_bit);
  modport framer (output rx_trib, output rx_bit, output rx_bit_valid, output tx_trib, output tx_bit_req, input tx_bit);
endinterface

// *** rtl/trib_link_pkg.sv ***
package trib_link_pkg;
  localparam int NUM_TRIB = 84;
  localparam int TRIB_W = 7;
  localparam int DEPTH = 128;
  localparam int PTR_W = 7;
  localparam int LVL_W = 8;
  localparam int NUM_SUM = 10;
  // register offsets, printed
  localparam logic [9:0] RX_BYTE_OFS = 10'h11a;
  localparam logic [9:0] RX_STAT_OFS = 10'h11b;
  localparam logic [9:0] TX_STAT_OFS = 10'h130;
  localparam logic [9:0] TX_BYTE_OFS = 10'h133;
  localparam logic [9:0] TX_CTRL_OFS = 10'h134;
  // own offsets
  localparam logic [9:0] RX_ADDR_OFS = 10'h118;
  localparam logic [9:0] RX_ISTAT_OFS = 10'h119;
  localparam logic [9:0] RX_CFG_OFS = 10'h11c;
  localparam logic [9:0] RX_INTC_OFS = 10'h11d;
  localparam logic [9:0] RX_SUM_OFS = 10'h100;
  localparam logic [9:0] TX_ADDR_OFS = 10'h131;
  localparam logic [9:0] TX_CFG_OFS = 10'h135;
  localparam logic [9:0] TX_UTHR_OFS = 10'h136;
  localparam logic [9:0] TX_LINT_OFS = 10'h137;
  localparam logic [9:0] TX_SUM_OFS = 10'h138;
  localparam logic [9:0] TX_FLAGS_OFS = 10'h139;
  // field positions
  localparam int ACCESS_BIT = 7;
  localparam int BUSY_BIT = 7;
  localparam int EMPTY_BIT = 6;
  localparam int OVR_BIT = 5;
  localparam int PACKET_RECEIVED_FLAG_BIT = 4;
  localparam int EOM_BIT = 0;
  localparam int DELINEATION_ENABLE_BIT = 0;
  localparam int ENABLE_BIT = 1;
  localparam logic [7:0] START_READ = 8'h40;
  localparam logic [7:0] FLAG_BYTE = 8'h7e;
  localparam logic [7:0] ABORT_BYTE = 8'hfe;
  localparam logic [2:0] BS_DATA = 3'b000;
  localparam logic [2:0] BS_FIRST = 3'b001;
  localparam logic [2:0] BS_ABORT = 3'b010;
  localparam logic [2:0] BS_LAST = 3'b100;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [15:0] CRC_GOOD = 16'hf0b8;
  localparam int CLK_HZ = 20000000;
  localparam int PRM_PERIOD_S = 1;
  localparam int PRM_CYCLES = CLK_HZ * PRM_PERIOD_S;
  localparam int PRM_LEN = 10;
  localparam logic [7:0] PRM_HDR0 = 8'h38;
  localparam logic [7:0] PRM_HDR1 = 8'h01;
  localparam logic [7:0] PRM_HDR2 = 8'h03;
  localparam int BUSY_CYCLES = 2;
  function automatic logic [15:0] crc_bit(input logic [15:0] c, input logic b);
    crc_bit = (c[0] ^ b) ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
  endfunction
endpackage
